// file: rtl/link_regs_defines.svh
`ifndef LINK_REGS_DEFINES_SVH
`define LINK_REGS_DEFINES_SVH

// ==========================================================================
// Register region decode
// ==========================================================================
`define REGION_BITS 12
`define ADDR_WORD_LSB 2

// ==========================================================================
// Register offsets
// ==========================================================================
`define OFF_VC_EXT_CAP_HEADER 12'h000
`define OFF_PORT_VC_CAP_ONE 12'h004
`define OFF_PORT_VC_CAP_TWO 12'h008
`define OFF_PORT_VC_CONTROL 12'h00c
`define OFF_CHAN0_RESOURCE_CAP 12'h010
`define OFF_CHAN0_RESOURCE_CONTROL 12'h014
`define OFF_CHAN0_STATUS_WORD 12'h018
`define OFF_CHAN0_RESOURCE_STATUS 12'h01a
`define OFF_CHAN1_RESOURCE_CAP 12'h01c
`define OFF_CHAN1_RESOURCE_CONTROL 12'h020
`define OFF_CHAN1_STATUS_WORD 12'h024
`define OFF_CHAN1_RESOURCE_STATUS 12'h026
`define OFF_LINK_CAPABILITIES 12'h084
`define OFF_LINK_CONTROL 12'h088
`define OFF_LINK_STATUS 12'h08a
`define OFF_LINK_TIMING_CONTROL 12'h208

// ==========================================================================
// Reset and constant values
// ==========================================================================
`define RST_VC_EXT_CAP_HEADER 32'h04010002
`define RST_PORT_VC_CAP_ONE 32'h00000001
`define RST_PORT_VC_CAP_TWO 32'h00000001
`define RST_PORT_VC_CONTROL 16'h0000
`define RST_CHAN0_RESOURCE_CAP 32'h00000001
`define RST_CHAN0_RESOURCE_CONTROL 32'h800000ff
`define RST_CHAN0_RESOURCE_STATUS 16'h0002
`define RST_CHAN1_RESOURCE_CAP 32'h00010001
`define RST_CHAN1_RESOURCE_CONTROL 32'h01000000
`define RST_CHAN1_RESOURCE_STATUS 16'h0002
`define RST_LINK_CAPABILITIES 32'h00002689
`define RST_LINK_CONTROL 16'h0000
`define RST_LINK_STATUS 16'h0001
`define RST_LINK_TIMING_CONTROL 32'h00007cb0

// ==========================================================================
// Writable masks and fields
// ==========================================================================
`define WM_PORT_VC_CAP_ONE 32'h00000007
`define WM_PORT_VC_CONTROL 16'h000e
`define WM_CHAN0_RESOURCE_CONTROL 32'h000000fe
`define WM_CHAN1_RESOURCE_CONTROL 32'h870000fe
`define WM_LINK_CONTROL 16'h00c3
`define WM_LINK_TIMING_CONTROL 32'hff27ffff
`define AGGR_L0S_BIT 21
`define CHAN_ENABLE_BIT 31
`define NEG_PENDING_BIT 1
`define HALF_WIDTH 16

// ==========================================================================
// Timing
// ==========================================================================
`define FTS_UNIT_NS 4
`define CLK_PERIOD_NS 25
`define AGGR_DIVISOR 4

`endif

// file: rtl/link_regs_pkg.sv
`default_nettype none

package link_regs_pkg;

    typedef logic [7:0] fts_t;
    typedef logic [15:0] count_t;

    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b01,
        ST_L0S = 2'b10
    } l0s_state_t;

endpackage

`default_nettype wire

// file: rtl/l0s_idle_timer.sv
`default_nettype none
`include "link_regs_defines.svh"

module l0s_idle_timer (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // Link side
    input wire logic i_link_idle,
    input wire link_regs_pkg::fts_t i_fts_count,
    input wire logic i_aggressive,
    output logic o_l0s_request
);
    import link_regs_pkg::*;

    l0s_state_t state_q;
    count_t idle_cnt_q;
    count_t fts_ns;
    count_t thr_normal;
    count_t thr_aggr;
    count_t threshold;

    // Whole idle time must elapse, so the cycle count rounds up.
    assign fts_ns = count_t'(i_fts_count) * count_t'(`FTS_UNIT_NS);
    assign thr_normal = count_t'((fts_ns + count_t'(`CLK_PERIOD_NS - 1)) /
                                 count_t'(`CLK_PERIOD_NS));
    assign thr_aggr = count_t'((fts_ns / count_t'(`AGGR_DIVISOR) +
                                count_t'(`CLK_PERIOD_NS - 1)) /
                               count_t'(`CLK_PERIOD_NS));

    // The threshold follows the policy bit live, so a change takes effect mid-count.
    always_comb begin
        threshold = i_aggressive ? thr_aggr : thr_normal;
        if (threshold == count_t'(0)) begin
            threshold = count_t'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            idle_cnt_q <= '0;
        end else if (i_ce) begin
            if (!i_link_idle || state_q == ST_L0S) begin
                idle_cnt_q <= '0;
            end else if (idle_cnt_q != '1) begin
                idle_cnt_q <= idle_cnt_q + count_t'(1);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_ACTIVE;
        end else if (i_ce) begin
            case (state_q)
                ST_ACTIVE: begin
                    if (i_link_idle && idle_cnt_q >= threshold - count_t'(1)) begin
                        state_q <= ST_L0S;
                    end
                end
                ST_L0S: begin
                    if (!i_link_idle) begin
                        state_q <= ST_ACTIVE;
                    end
                end
                default: begin
                    state_q <= ST_ACTIVE;
                end
            endcase
        end
    end

    assign o_l0s_request = (state_q == ST_L0S);

endmodule

`default_nettype wire

// file: rtl/link_root_complex_regs.sv
`default_nettype none
`include "link_regs_defines.svh"

// Behaviour
// - Normal L0s wait is FTS count times 4ns.
// - Aggressive bit cuts the wait to one quarter.
// - Aggressive bit resets clear, applies live.
// - Timing control register lives at offset 208h.
// - Block decodes at software-programmed base pointer.
// - First extended capability starts at offset zero.
// - Register offsets follow the fixed map.
// - Capability header reads constant 04010002h.
// - Port capability one resets 1, write-once count.
// - Port capability two reads constant 1.
// - Channel 0 control at 014h, resets 800000FFh.
// - Channel 1 control at 020h, resets 01000000h.
// - Channel 0 status at 01Ah resets 0002h.
// - Channel 1 wins arbitration over channel 0 only while its enable bit is set.
module link_root_complex_regs (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // Base pointer from host device configuration space
    input wire logic [31:0] i_base_ptr,
    input wire logic i_base_enable,
    // Memory-mapped register access
    input wire logic i_mem_req,
    input wire logic i_mem_write,
    input wire logic [31:0] i_mem_addr,
    input wire logic [31:0] i_mem_wdata,
    input wire logic [3:0] i_mem_be,
    output logic o_mem_ready,
    output logic [31:0] o_mem_rdata,
    // Link state
    input wire logic i_link_idle,
    input wire link_regs_pkg::fts_t i_fts_count,
    input wire logic i_chan0_negotiated,
    input wire logic i_chan1_negotiated,
    // Channel arbitration
    input wire logic i_chan0_req,
    input wire logic i_chan1_req,
    output logic o_chan0_grant,
    output logic o_chan1_grant,
    // Control outputs
    output logic o_l0s_request,
    output logic o_aggressive_l0s,
    output logic o_chan1_enable
);
    import link_regs_pkg::*;

    // ======================================================================
    // Helper functions
    // ======================================================================
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] cur,
                                          input logic [31:0] wdata,
                                          input logic [31:0] wmask,
                                          input logic [3:0] be);
        logic [31:0] m;
        m = wmask & lane_mask(be);
        merge = (cur & ~m) | (wdata & m);
    endfunction

    // ======================================================================
    // Address decode
    // ======================================================================
    logic region_hit;
    logic [`REGION_BITS-1:0] offset;
    logic wr_stb;
    logic rd_stb;

    // Nothing answers until software has enabled the base pointer.
    assign region_hit = i_base_enable &&
        (i_mem_addr[31:`REGION_BITS] == i_base_ptr[31:`REGION_BITS]);
    assign offset = {i_mem_addr[`REGION_BITS-1:`ADDR_WORD_LSB], 2'b00};
    assign wr_stb = i_ce && i_mem_req && i_mem_write && region_hit;
    assign rd_stb = i_ce && i_mem_req && !i_mem_write && region_hit;

    // ======================================================================
    // Writable registers
    // ======================================================================
    logic [31:0] port_vc_cap_one_q;
    logic cap_one_locked_q;
    logic [15:0] port_vc_control_q;
    logic [31:0] chan0_resource_control_q;
    logic [31:0] chan1_resource_control_q;
    logic [15:0] link_control_q;
    logic [31:0] link_timing_control_q;
    logic [15:0] chan0_resource_status_q;
    logic [15:0] chan1_resource_status_q;

    // The extended channel count may be written once only; later writes are dropped.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            port_vc_cap_one_q <= `RST_PORT_VC_CAP_ONE;
            cap_one_locked_q <= 1'b0;
        end else if (wr_stb && offset == `OFF_PORT_VC_CAP_ONE && !cap_one_locked_q) begin
            port_vc_cap_one_q <= merge(port_vc_cap_one_q, i_mem_wdata,
                                       `WM_PORT_VC_CAP_ONE, i_mem_be);
            cap_one_locked_q <= i_mem_be[0];
        end
    end

    // The load bit of this register is never stored and always reads zero.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            port_vc_control_q <= `RST_PORT_VC_CONTROL;
        end else if (wr_stb && offset == `OFF_PORT_VC_CONTROL) begin
            port_vc_control_q <= 16'(merge({16'h0000, port_vc_control_q}, i_mem_wdata,
                                           {16'h0000, `WM_PORT_VC_CONTROL}, i_mem_be));
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            chan0_resource_control_q <= `RST_CHAN0_RESOURCE_CONTROL;
        end else if (wr_stb && offset == `OFF_CHAN0_RESOURCE_CONTROL) begin
            chan0_resource_control_q <= merge(chan0_resource_control_q, i_mem_wdata,
                                              `WM_CHAN0_RESOURCE_CONTROL, i_mem_be);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            chan1_resource_control_q <= `RST_CHAN1_RESOURCE_CONTROL;
        end else if (wr_stb && offset == `OFF_CHAN1_RESOURCE_CONTROL) begin
            chan1_resource_control_q <= merge(chan1_resource_control_q, i_mem_wdata,
                                              `WM_CHAN1_RESOURCE_CONTROL, i_mem_be);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            link_control_q <= `RST_LINK_CONTROL;
        end else if (wr_stb && offset == `OFF_LINK_CONTROL) begin
            link_control_q <= 16'(merge({16'h0000, link_control_q}, i_mem_wdata,
                                        {16'h0000, `WM_LINK_CONTROL}, i_mem_be));
        end
    end

    // Policy bit may be rewritten at run time; the timer reads it directly.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            link_timing_control_q <= `RST_LINK_TIMING_CONTROL;
        end else if (wr_stb && offset == `OFF_LINK_TIMING_CONTROL) begin
            link_timing_control_q <= merge(link_timing_control_q, i_mem_wdata,
                                           `WM_LINK_TIMING_CONTROL, i_mem_be);
        end
    end

    // ======================================================================
    // Channel status
    // ======================================================================
    // Negotiation-pending clears once the far end reports the channel is up; channel 1 holds it set while its enable bit is clear.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            chan0_resource_status_q <= `RST_CHAN0_RESOURCE_STATUS;
        end else if (i_ce && i_chan0_negotiated) begin
            chan0_resource_status_q[`NEG_PENDING_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            chan1_resource_status_q <= `RST_CHAN1_RESOURCE_STATUS;
        end else if (i_ce) begin
            if (!chan1_resource_control_q[`CHAN_ENABLE_BIT]) begin
                chan1_resource_status_q[`NEG_PENDING_BIT] <= 1'b1;
            end else if (i_chan1_negotiated) begin
                chan1_resource_status_q[`NEG_PENDING_BIT] <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Read path
    // ======================================================================
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = 32'h00000000;
        case (offset)
            `OFF_VC_EXT_CAP_HEADER: begin
                rdata_d = `RST_VC_EXT_CAP_HEADER;
            end
            `OFF_PORT_VC_CAP_ONE: begin
                rdata_d = port_vc_cap_one_q;
            end
            `OFF_PORT_VC_CAP_TWO: begin
                rdata_d = `RST_PORT_VC_CAP_TWO;
            end
            `OFF_PORT_VC_CONTROL: begin
                rdata_d = {16'h0000, port_vc_control_q & `WM_PORT_VC_CONTROL};
            end
            `OFF_CHAN0_RESOURCE_CAP: begin
                rdata_d = `RST_CHAN0_RESOURCE_CAP;
            end
            `OFF_CHAN0_RESOURCE_CONTROL: begin
                rdata_d = chan0_resource_control_q;
            end
            `OFF_CHAN0_STATUS_WORD: begin
                rdata_d = {chan0_resource_status_q, 16'h0000};
            end
            `OFF_CHAN1_RESOURCE_CAP: begin
                rdata_d = `RST_CHAN1_RESOURCE_CAP;
            end
            `OFF_CHAN1_RESOURCE_CONTROL: begin
                rdata_d = chan1_resource_control_q;
            end
            `OFF_CHAN1_STATUS_WORD: begin
                rdata_d = {chan1_resource_status_q, 16'h0000};
            end
            `OFF_LINK_CAPABILITIES: begin
                rdata_d = `RST_LINK_CAPABILITIES;
            end
            `OFF_LINK_CONTROL: begin
                rdata_d = {`RST_LINK_STATUS, link_control_q};
            end
            `OFF_LINK_TIMING_CONTROL: begin
                rdata_d = link_timing_control_q;
            end
            default: begin
                rdata_d = 32'h00000000;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mem_rdata <= 32'h00000000;
        end else if (rd_stb) begin
            o_mem_rdata <= rdata_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mem_ready <= 1'b0;
        end else if (i_ce) begin
            o_mem_ready <= rd_stb || wr_stb;
        end
    end

    // ======================================================================
    // Channel arbitration
    // ======================================================================
    // Fixed priority: a disabled channel 1 can never starve channel 0.
    always_comb begin
        o_chan1_grant = i_chan1_req && chan1_resource_control_q[`CHAN_ENABLE_BIT];
        o_chan0_grant = i_chan0_req && !o_chan1_grant;
    end

    assign o_chan1_enable = chan1_resource_control_q[`CHAN_ENABLE_BIT];
    assign o_aggressive_l0s = link_timing_control_q[`AGGR_L0S_BIT];

    // ======================================================================
    // L0s entry timer
    // ======================================================================
    l0s_idle_timer u_l0s_idle_timer (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_link_idle(i_link_idle),
        .i_fts_count(i_fts_count),
        .i_aggressive(link_timing_control_q[`AGGR_L0S_BIT]),
        .o_l0s_request(o_l0s_request)
    );

endmodule

`default_nettype wire

// file: rtl/placeholder_never.sv
`default_nettype none
`default_nettype wire

// file: test/link_regs_asserts.sv
`default_nettype none
module link_regs_asserts (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // Register access
    input wire logic [31:0] i_base_ptr,
    input wire logic i_base_enable,
    input wire logic i_mem_req,
    input wire logic i_mem_write,
    input wire logic [31:0] i_mem_addr,
    input wire logic [31:0] i_mem_wdata,
    input wire logic [3:0] i_mem_be,
    input wire logic o_mem_ready,
    input wire logic [31:0] o_mem_rdata,
    // Link and arbitration
    input wire logic i_link_idle,
    input wire link_regs_pkg::fts_t i_fts_count,
    input wire logic i_chan0_req,
    input wire logic i_chan1_req,
    input wire logic o_chan0_grant,
    input wire logic o_chan1_grant,
    input wire logic o_l0s_request,
    input wire logic o_aggressive_l0s,
    input wire logic o_chan1_enable
);
    import link_regs_pkg::*;
    // ====
    // Helpers
    logic hit;
    logic [11:0] off;
    int thr;
    logic [7:0] run_q;
    assign off = {i_mem_addr[11:2], 2'b00};
    assign hit = i_ce && i_mem_req && i_base_enable && (i_mem_addr[31:12] == i_base_ptr[31:12]);
    // The threshold follows the sampled policy bit, which is the value the timer uses.
    always_comb begin
        thr = o_aggressive_l0s ? (int'(i_fts_count) + 24) / 25 : (int'(i_fts_count) * 4 + 24) / 25;
        if (thr < 1) thr = 1;
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            run_q <= 8'h00;
        end else if (i_ce) begin
            run_q <= !i_link_idle ? 8'h00 : ((run_q == 8'hff) ? run_q : run_q + 8'h01);
        end
    end
    // ====
    // Properties
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_rd(logic [11:0] o);
        hit && !i_mem_write && (off == o);
    endsequence
    sequence s_idle_done;
        i_ce && i_link_idle && (run_q + 1 >= thr);
    endsequence
    AST_READY_ONE: assert property (hit |=> o_mem_ready)
        else $error("no ready after a taken access");
    AST_MISS_SILENT: assert property (i_ce && i_mem_req && !hit |=> !o_mem_ready)
        else $error("ready after a missed access");
    AST_HDR_CONST: assert property (s_rd(12'h000) |=> o_mem_rdata == 32'h04010002)
        else $error("capability header wrong");
    AST_CAP_TWO_CONST: assert property (s_rd(12'h008) |=> o_mem_rdata == 32'h00000001)
        else $error("port capability two wrong");
    AST_RSVD_ZERO: assert property (hit && !i_mem_write && off >= 12'h08c && off != 12'h208
        |=> o_mem_rdata == 32'h0)
        else $error("reserved offset not zero");
    AST_AGGR_WRITE: assert property (hit && i_mem_write && off == 12'h208 && i_mem_be[2]
        |=> o_aggressive_l0s == $past(i_mem_wdata[21]))
        else $error("policy bit not written");
    AST_AGGR_HOLD: assert property (!$stable(o_aggressive_l0s)
        |-> $past(hit && i_mem_write && off == 12'h208))
        else $error("policy bit changed without a write");
    AST_GRANT_PRIO: assert property (o_chan1_grant == (i_chan1_req && o_chan1_enable)
        && o_chan0_grant == (i_chan0_req && !o_chan1_grant))
        else $error("arbitration priority wrong");
    AST_L0S_REACH: assert property (s_idle_done |=> o_l0s_request)
        else $error("no entry after idle threshold");
    AST_L0S_EARLY: assert property ($rose(o_l0s_request)
        |-> $past(i_link_idle) && ($past(run_q) + 1 >= $past(thr)))
        else $error("entry before idle threshold");
    AST_L0S_DROP: assert property (i_ce && !i_link_idle |=> !o_l0s_request)
        else $error("entry held during traffic");
endmodule
`default_nettype wire

// file: test/link_hub_model.sv
`default_nettype none
module link_hub_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Commands from the bench
    input wire logic i_send,
    input wire logic i_train,
    // Link state toward the root complex
    output logic o_link_idle,
    output logic o_chan0_negotiated,
    output logic o_chan1_negotiated
);
    logic send_q;
    logic train_q;
    // Traffic starts and stops one edge after the command, as a packet cannot be cut short.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            send_q <= 1'b0;
            train_q <= 1'b0;
        end else begin
            send_q <= i_send;
            train_q <= i_train;
        end
    end
    assign o_link_idle = !send_q;
    assign o_chan0_negotiated = train_q;
    assign o_chan1_negotiated = train_q;
endmodule
`default_nettype wire

// file: test/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import link_regs_pkg::*;
    typedef struct packed {
        logic wr;
        logic [11:0] off;
        logic [31:0] wd;
        logic [3:0] be;
        logic [31:0] exp;
    } row_t;
    localparam logic [31:0] BASE = 32'hfed18000;
    logic i_clk = 1'b0;
    logic i_rst_n, i_base_enable, i_mem_req, i_mem_write, o_mem_ready, rdy;
    logic [31:0] i_mem_addr, i_mem_wdata, o_mem_rdata, rd;
    logic [3:0] i_mem_be;
    logic link_idle, neg0, neg1, i_chan0_req, i_chan1_req, o_chan0_grant, o_chan1_grant;
    logic o_l0s_request, o_aggressive_l0s, o_chan1_enable, send, train, ce;
    int n_errors = 0;
    int samples_checked = 0;
    row_t rows [27] = '{
        '{1'b0, 12'h000, 32'h0, 4'h0, 32'h04010002},
        '{1'b0, 12'h004, 32'h0, 4'h0, 32'h00000001},
        '{1'b0, 12'h008, 32'h0, 4'h0, 32'h00000001},
        '{1'b0, 12'h00c, 32'h0, 4'h0, 32'h00000000},
        '{1'b0, 12'h010, 32'h0, 4'h0, 32'h00000001},
        '{1'b0, 12'h014, 32'h0, 4'h0, 32'h800000ff},
        '{1'b0, 12'h018, 32'h0, 4'h0, 32'h00020000},
        '{1'b0, 12'h01c, 32'h0, 4'h0, 32'h00010001},
        '{1'b0, 12'h020, 32'h0, 4'h0, 32'h01000000},
        '{1'b0, 12'h024, 32'h0, 4'h0, 32'h00020000},
        '{1'b0, 12'h084, 32'h0, 4'h0, 32'h00002689},
        '{1'b0, 12'h088, 32'h0, 4'h0, 32'h00010000},
        '{1'b0, 12'h208, 32'h0, 4'h0, 32'h00007cb0},
        '{1'b1, 12'h100, 32'hffffffff, 4'hf, 32'h0},
        '{1'b0, 12'h100, 32'h0, 4'h0, 32'h00000000},
        '{1'b1, 12'h000, 32'hffffffff, 4'hf, 32'h0},
        '{1'b0, 12'h000, 32'h0, 4'h0, 32'h04010002},
        '{1'b1, 12'h004, 32'h00000006, 4'h1, 32'h0},
        '{1'b1, 12'h004, 32'h00000003, 4'h1, 32'h0},
        '{1'b0, 12'h004, 32'h0, 4'h0, 32'h00000006},
        '{1'b1, 12'h014, 32'h00000000, 4'hf, 32'h0},
        '{1'b0, 12'h014, 32'h0, 4'h0, 32'h80000001},
        '{1'b1, 12'h020, 32'hffffffff, 4'hf, 32'h0},
        '{1'b0, 12'h020, 32'h0, 4'h0, 32'h870000fe},
        '{1'b1, 12'h208, 32'hffffffff, 4'hf, 32'h0},
        '{1'b0, 12'h208, 32'h0, 4'h0, 32'hff27ffff},
        '{1'b1, 12'h208, 32'h00007cb0, 4'hf, 32'h0}
    };
    always #12.5 i_clk = ~i_clk;
    // ====
    // Tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic access(input logic wr, input logic [11:0] off, input logic [31:0] wd,
                          input logic [3:0] be, input logic [31:0] base);
        @(negedge i_clk);
        i_mem_req = 1'b1;
        i_mem_write = wr;
        i_mem_addr = base | {20'h0, off};
        i_mem_wdata = wd;
        i_mem_be = be;
        @(negedge i_clk);
        i_mem_req = 1'b0;
        rdy = o_mem_ready;
        rd = o_mem_rdata;
    endtask
    task automatic measure(input int gap, input int thr);
        int n;
        n = 0;
        @(negedge i_clk);
        send = 1'b1;
        repeat (3) @(negedge i_clk);
        check({31'h0, o_l0s_request}, 32'h0);
        if (gap > 0) begin
            send = 1'b0;
            repeat (gap) @(negedge i_clk);
            send = 1'b1;
            @(negedge i_clk);
        end
        send = 1'b0;
        while (o_l0s_request !== 1'b1 && n < 100) begin
            @(negedge i_clk);
            n++;
        end
        check(n, thr + 1);
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ====
    // Sequence
    initial begin
        {i_rst_n, i_mem_req, i_mem_write, send, train, i_chan0_req, i_chan1_req} = 7'h00;
        {i_mem_addr, i_mem_wdata, i_mem_be, i_base_enable, ce} = {68'h0, 2'b11};
        repeat (20) @(negedge i_clk);
        i_rst_n = 1'b1;
        foreach (rows[i]) begin
            access(rows[i].wr, rows[i].off, rows[i].wd, rows[i].be, BASE);
            check({31'h0, rdy}, 32'h1);
            if (!rows[i].wr) check(rd, rows[i].exp);
        end
        i_base_enable = 1'b0;
        access(1'b0, 12'h000, 32'h0, 4'h0, BASE);
        check({31'h0, rdy}, 32'h0);
        i_base_enable = 1'b1;
        access(1'b0, 12'h000, 32'h0, 4'h0, BASE ^ 32'h00001000);
        check({31'h0, rdy}, 32'h0);
        {i_chan0_req, i_chan1_req, train} = 3'b111;
        @(negedge i_clk);
        check({30'h0, o_chan1_grant, o_chan0_grant}, 32'h2);
        access(1'b0, 12'h018, 32'h0, 4'h0, BASE);
        check(rd, 32'h0);
        access(1'b0, 12'h024, 32'h0, 4'h0, BASE);
        check(rd, 32'h0);
        measure(0, 8);
        measure(4, 8);
        access(1'b1, 12'h208, 32'h00200000, 4'h4, BASE);
        check({31'h0, o_aggressive_l0s}, 32'h1);
        measure(0, 2);
        @(negedge i_clk);
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_clk);
        i_rst_n = 1'b1;
        ce = 1'b0;
        access(1'b1, 12'h208, 32'hffffffff, 4'hf, BASE);
        ce = 1'b1;
        check({29'h0, rdy, o_chan1_enable, o_aggressive_l0s}, 32'h0);
        check({30'h0, o_chan1_grant, o_chan0_grant}, 32'h1);
        access(1'b0, 12'h020, 32'h0, 4'h0, BASE);
        check(rd, 32'h01000000);
        measure(0, 8);
        end_of_test();
    end
    // The whole run needs some 150 cycles; the limit of 20000 cycles leaves a wide margin.
    initial begin
        #(25 * 20000);
        n_errors++;
        end_of_test();
    end
    link_hub_model hub (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_send(send), .i_train(train),
        .o_link_idle(link_idle), .o_chan0_negotiated(neg0), .o_chan1_negotiated(neg1)
    );
    link_root_complex_regs dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_base_ptr(BASE),
        .i_base_enable(i_base_enable), .i_mem_req(i_mem_req), .i_mem_write(i_mem_write),
        .i_mem_addr(i_mem_addr), .i_mem_wdata(i_mem_wdata), .i_mem_be(i_mem_be),
        .o_mem_ready(o_mem_ready), .o_mem_rdata(o_mem_rdata), .i_link_idle(link_idle),
        .i_fts_count(8'h32), .i_chan0_negotiated(neg0), .i_chan1_negotiated(neg1),
        .i_chan0_req(i_chan0_req), .i_chan1_req(i_chan1_req), .o_chan0_grant(o_chan0_grant),
        .o_chan1_grant(o_chan1_grant), .o_l0s_request(o_l0s_request),
        .o_aggressive_l0s(o_aggressive_l0s), .o_chan1_enable(o_chan1_enable)
    );
endmodule
bind link_root_complex_regs link_regs_asserts chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_base_ptr(i_base_ptr),
    .i_base_enable(i_base_enable), .i_mem_req(i_mem_req), .i_mem_write(i_mem_write),
    .i_mem_addr(i_mem_addr), .i_mem_wdata(i_mem_wdata), .i_mem_be(i_mem_be),
    .o_mem_ready(o_mem_ready),
    .o_mem_rdata(o_mem_rdata), .i_link_idle(i_link_idle), .i_fts_count(i_fts_count),
    .i_chan0_req(i_chan0_req), .i_chan1_req(i_chan1_req), .o_chan0_grant(o_chan0_grant),
    .o_chan1_grant(o_chan1_grant), .o_l0s_request(o_l0s_request),
    .o_aggressive_l0s(o_aggressive_l0s), .o_chan1_enable(o_chan1_enable)
);
`default_nettype wire
